//--- design/rtp_pkg.sv
/*
 * rtp_pkg: shared constants and types for the relay / pwm output channel.
 * assumes a 10 MHz system clock; time settings arrive in tenths of a second, delays in tenths of a minute when the minute unit is selected.
 */
package rtp_pkg;

	localparam int unsigned RTP_CLK_HZ      = 10000000;
	localparam int unsigned RTP_TENTH_MS    = 100;
	localparam int unsigned RTP_TENTH_CYC   = RTP_CLK_HZ / 1000 * RTP_TENTH_MS;
	localparam int unsigned RTP_MIN_TENTHS  = 600;

	localparam logic signed [15:0] RTP_THR_MIN    = 16'shfc19;
	localparam logic signed [15:0] RTP_THR_MAX    = 16'sh270f;
	localparam logic        [9:0]  RTP_MARGIN_MAX = 10'h3e7;
	localparam logic        [9:0]  RTP_DELAY_MAX  = 10'h3e7;
	localparam logic        [13:0] RTP_CYCLE_MAX  = 14'h270f;
	localparam logic        [6:0]  RTP_FILL_FULL  = 7'h64;

	typedef enum logic [1:0] {
		RTP_SRC_MEAS,
		RTP_SRC_BUS,
		RTP_SRC_HEAT,
		RTP_SRC_COOL
	} rtp_src_e;

	typedef enum logic [2:0] {
		RTP_MODE_DISABLED,
		RTP_MODE_ON,
		RTP_MODE_OFF,
		RTP_MODE_IN,
		RTP_MODE_OUT,
		RTP_MODE_PWM
	} rtp_mode_e;

	// relay reactions; pwm reactions reuse codes 0..2 as ignore, hold, forced fill
	typedef enum logic [1:0] {
		RTP_ALM_HOLD,
		RTP_ALM_ON,
		RTP_ALM_OFF
	} rtp_alm_e;

	localparam logic [1:0] RTP_PWM_IGNORE = 2'h0;
	localparam logic [1:0] RTP_PWM_HOLD   = 2'h1;
	localparam logic [1:0] RTP_PWM_FORCED = 2'h2;

endpackage

//--- design/rtp_tick_if.sv
/*
 * rtp_tick_if: carries the time-base pulses from the divider to the channel.
 * assumes one sys_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
interface rtp_tick_if;
	logic tenth;
	logic delay_tick;
	modport src (output tenth, output delay_tick);
	modport dst (input tenth, input delay_tick);
endinterface
`default_nettype wire

//--- design/rtp_timebase.sv
/*
 * rtp_timebase: divides sys_clk into a 0.1 s pulse and a delay pulse that is
 * either the same 0.1 s pulse or one every 0.1 min, per unit select.
 * assumes sys_clk at the package rate.
 */
`timescale 1ns/1ps
`default_nettype none
module rtp_timebase
	import rtp_pkg::*;
#(
	parameter int unsigned TENTH_CYC = RTP_TENTH_CYC
) (
	input  wire logic sys_clk,
	input  wire logic nrst,
	input  wire logic unit_minutes,
	rtp_tick_if.src   tick
);
	typedef struct packed {
		logic [23:0] div;
		logic [5:0]  sec;
		logic        tenth;
		logic        dtick;
	} rtp_tb_s;

	rtp_tb_s st_reg;
	rtp_tb_s st_next;

	always_comb begin
		st_next       = st_reg;
		st_next.tenth = 1'b0;
		st_next.dtick = 1'b0;
		if (st_reg.div == 24'(TENTH_CYC - 1)) begin
			st_next.div   = '0;
			st_next.tenth = 1'b1;
			// a minute-unit tenth is sixty second-unit tenths
			if (st_reg.sec == 6'(RTP_MIN_TENTHS / 10 - 1)) begin
				st_next.sec = '0;
			end else begin
				st_next.sec = st_reg.sec + 6'h01;
			end
			st_next.dtick = unit_minutes ? (st_reg.sec == 6'(RTP_MIN_TENTHS / 10 - 1)) : 1'b1;
		end else begin
			st_next.div = st_reg.div + 24'h000001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tick.tenth      = st_reg.tenth;
	assign tick.delay_tick = st_reg.dtick;
endmodule
`default_nettype wire

//--- design/rtp_channel.sv
/*
 * rtp_channel: one relay / open-collector output channel with threshold,
 * window, delay, gating, alarm and pwm behaviour.
 * assumes settings are held stable by a settings store on the same clock and
 * that sample_valid pulses one cycle with each new source sample.
 */
`timescale 1ns/1ps
`default_nettype none
module rtp_channel
	import rtp_pkg::*;
#(
	parameter int unsigned TENTH_CYC = RTP_TENTH_CYC
) (
	input  wire logic               sys_clk,
	input  wire logic               nrst,
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] meas_value,
	input  wire logic               meas_over_range,
	input  wire logic signed [15:0] bus_value,
	input  wire logic signed [15:0] heat_value,
	input  wire logic signed [15:0] cool_value,
	input  wire logic signed [15:0] loop_setpoint,
	input  wire logic [1:0]         source_select,
	input  wire logic [2:0]         relay_mode,
	input  wire logic signed [15:0] primary_threshold,
	input  wire logic signed [15:0] secondary_threshold,
	input  wire logic [9:0]         switching_margin,
	input  wire logic [9:0]         setpoint_deviation_gate,
	input  wire logic [6:0]         controller_output_gate,
	input  wire logic [9:0]         activation_delay,
	input  wire logic [9:0]         deactivation_delay,
	input  wire logic               delay_unit_minutes,
	input  wire logic signed [15:0] pwm_span_floor,
	input  wire logic signed [15:0] pwm_span_ceiling,
	input  wire logic [13:0]        pwm_cycle_length,
	input  wire logic [13:0]        min_high_interval,
	input  wire logic [13:0]        min_low_interval,
	input  wire logic [1:0]         critical_reaction,
	input  wire logic [6:0]         alarm_fill,
	output logic                    relay_out,
	output logic                    open_collector_output,
	output logic                    indicator_led,
	output logic                    alarm_active,
	output logic [6:0]              fill_percent
);
	rtp_tick_if tick ();

	rtp_timebase #(
		.TENTH_CYC    (TENTH_CYC)
	) u_timebase (
		.sys_clk      (sys_clk),
		.nrst         (nrst),
		.unit_minutes (delay_unit_minutes),
		.tick         (tick)
	);

	typedef struct packed {
		logic signed [15:0] src;
		logic               alarm;
		logic               thr_state;
		logic               out;
		logic [9:0]         dly_cnt;
		logic [13:0]        pwm_pos;
		logic [13:0]        high_len;
		logic [6:0]         fill;
		logic               pwm_out;
	} rtp_ch_s;

	rtp_ch_s st_reg;
	rtp_ch_s st_next;

	function automatic logic signed [17:0] ext(input logic signed [15:0] v);
		return 18'(v);
	endfunction

	function automatic logic [6:0] clamp_fill(input logic signed [15:0] v,
			input logic signed [15:0] lo, input logic signed [15:0] hi);
		logic signed [31:0] num;
		logic signed [31:0] den;
		num = 32'(v) - 32'(lo);
		den = 32'(hi) - 32'(lo);
		if (v <= lo) begin
			return 7'h00;
		end else if (v >= hi || den <= 0) begin
			return RTP_FILL_FULL;
		end
		return 7'((num * 32'sd100) / den);
	endfunction

	logic signed [15:0] src_sel;
	logic signed [17:0] thr_lo;
	logic signed [17:0] thr_hi;
	logic signed [17:0] mrg;
	logic               want_on;
	logic               want_off;
	logic               gate_ok;
	logic [9:0]         dly_lim;
	logic [14:0]        min_sum;
	logic [13:0]        hi_calc;
	logic [6:0]         eff_fill;
	logic signed [15:0] dev;
	logic [15:0]        dev_abs;
	logic               pwm_alarm_hold;

	always_comb begin
		unique case (rtp_src_e'(source_select))
			RTP_SRC_MEAS: src_sel = meas_value;
			RTP_SRC_BUS:  src_sel = bus_value;
			RTP_SRC_HEAT: src_sel = heat_value;
			RTP_SRC_COOL: src_sel = cool_value;
		endcase
	end

	always_comb begin
		st_next        = st_reg;
		mrg            = 18'(switching_margin);
		// the window modes order the two thresholds themselves
		if (primary_threshold <= secondary_threshold) begin
			thr_lo = ext(primary_threshold);
			thr_hi = ext(secondary_threshold);
		end else begin
			thr_lo = ext(secondary_threshold);
			thr_hi = ext(primary_threshold);
		end
		want_on  = 1'b0;
		want_off = 1'b0;
		unique case (relay_mode)
			RTP_MODE_ON: begin
				want_on  = ext(st_reg.src) > ext(primary_threshold) + mrg;
				want_off = ext(st_reg.src) < ext(primary_threshold) - mrg;
			end
			RTP_MODE_OFF: begin
				want_off = ext(st_reg.src) > ext(primary_threshold) + mrg;
				want_on  = ext(st_reg.src) < ext(primary_threshold) - mrg;
			end
			RTP_MODE_IN: begin
				want_on  = ext(st_reg.src) > thr_lo + mrg && ext(st_reg.src) < thr_hi - mrg;
				want_off = ext(st_reg.src) < thr_lo - mrg || ext(st_reg.src) > thr_hi + mrg;
			end
			RTP_MODE_OUT: begin
				want_on  = ext(st_reg.src) > thr_hi + mrg || ext(st_reg.src) < thr_lo - mrg;
				want_off = ext(st_reg.src) > thr_lo + mrg && ext(st_reg.src) < thr_hi - mrg;
			end
			default: begin
				want_on  = 1'b0;
				want_off = 1'b0;
			end
		endcase

		// gating applies only to the control-loop sources
		dev     = 16'(loop_setpoint - st_reg.src);
		dev_abs = dev[15] ? 16'(-dev) : 16'(dev);
		gate_ok = 1'b1;
		if (source_select == 2'(RTP_SRC_HEAT) || source_select == 2'(RTP_SRC_COOL)) begin
			if (setpoint_deviation_gate != 10'h000 && dev_abs < 16'(setpoint_deviation_gate)) begin
				gate_ok = 1'b0;
			end
			// signed compare: a negative controller output must not pass the gate
			if (controller_output_gate != 7'h00 && st_reg.src < $signed(16'(controller_output_gate))) begin
				gate_ok = 1'b0;
			end
		end
		want_on = want_on & gate_ok;

		if (sample_valid) begin
			st_next.src   = src_sel;
			st_next.alarm = meas_over_range;
		end

		// delay timer: counts while the far border is held, restarts on retreat
		dly_lim = st_reg.thr_state ? deactivation_delay : activation_delay;
		if ((st_reg.thr_state ? want_off : want_on)) begin
			if (st_reg.dly_cnt >= dly_lim) begin
				st_next.thr_state = ~st_reg.thr_state;
				st_next.dly_cnt   = '0;
			end else if (tick.delay_tick) begin
				st_next.dly_cnt = st_reg.dly_cnt + 10'h001;
			end
		end else begin
			st_next.dly_cnt = '0;
		end
		// unused mode codes 6 and 7 behave as disabled
		if (relay_mode == 3'(RTP_MODE_DISABLED) || relay_mode >= 3'(RTP_MODE_PWM)) begin
			st_next.thr_state = 1'b0;
			st_next.dly_cnt   = '0;
		end

		// relay output with alarm reaction
		st_next.out = st_next.thr_state;
		if (st_reg.alarm && relay_mode != 3'(RTP_MODE_PWM)) begin
			unique case (critical_reaction)
				2'(RTP_ALM_ON):  st_next.out = 1'b1;
				2'(RTP_ALM_OFF): st_next.out = 1'b0;
				default:         st_next.out = st_reg.out;
			endcase
		end
		if (relay_mode == 3'(RTP_MODE_PWM)) begin
			st_next.out = 1'b0;
		end

		// pwm: the fill is latched at each cycle start so a cycle is never cut
		pwm_alarm_hold = 1'b0;
		eff_fill       = clamp_fill(st_reg.src, pwm_span_floor, pwm_span_ceiling);
		if (st_reg.alarm) begin
			unique case (critical_reaction)
				RTP_PWM_HOLD:   pwm_alarm_hold = 1'b1;
				RTP_PWM_FORCED: eff_fill = (alarm_fill > RTP_FILL_FULL) ? RTP_FILL_FULL : alarm_fill;
				default:        eff_fill = eff_fill;
			endcase
		end
		hi_calc = 14'((28'(pwm_cycle_length) * 28'(eff_fill)) / 28'd100);
		if (eff_fill != 7'h00 && hi_calc < min_high_interval) begin
			hi_calc = min_high_interval;
		end
		if (eff_fill != RTP_FILL_FULL && 15'(hi_calc) + 15'(min_low_interval) > 15'(pwm_cycle_length)) begin
			hi_calc = 14'(pwm_cycle_length - min_low_interval);
		end
		min_sum = 15'(min_high_interval) + 15'(min_low_interval);

		if (relay_mode != 3'(RTP_MODE_PWM)) begin
			st_next.pwm_pos  = '0;
			st_next.pwm_out  = 1'b0;
			st_next.fill     = '0;
		end else if (min_sum > 15'(pwm_cycle_length) || pwm_cycle_length == 14'h0000) begin
			st_next.pwm_out = 1'b0;
			st_next.pwm_pos = '0;
		end else if (pwm_alarm_hold) begin
			st_next.pwm_out = st_reg.pwm_out;
		end else if (tick.tenth) begin
			if (st_reg.pwm_pos == 14'h0000) begin
				st_next.high_len = hi_calc;
				st_next.fill     = eff_fill;
				st_next.pwm_out  = hi_calc != 14'h0000;
			end else begin
				st_next.pwm_out  = st_reg.pwm_pos < st_reg.high_len;
			end
			if (st_reg.pwm_pos >= pwm_cycle_length - 14'h0001) begin
				st_next.pwm_pos = '0;
			end else begin
				st_next.pwm_pos = st_reg.pwm_pos + 14'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg                <= '0;
			relay_out             <= 1'b0;
			open_collector_output <= 1'b0;
			indicator_led         <= 1'b0;
			alarm_active          <= 1'b0;
			fill_percent          <= '0;
		end else begin
			st_reg                <= st_next;
			relay_out             <= st_next.out;
			open_collector_output <= st_next.pwm_out;
			indicator_led         <= st_next.out | st_next.pwm_out;
			alarm_active          <= st_next.alarm;
			fill_percent          <= st_next.fill;
		end
	end
endmodule
`default_nettype wire

//--- tb/rtp_chk_sva.sv
/* rtp_chk: assertions on the ports of rtp_channel.
   assumes settings stay steady across each sample. */
`timescale 1ns/1ps
`default_nettype none
module rtp_chk
	import rtp_pkg::*;
(
	input wire logic               sys_clk,
	input wire logic               nrst,
	input wire logic               sample_valid,
	input wire logic signed [15:0] meas_value,
	input wire logic               meas_over_range,
	input wire logic [1:0]         source_select,
	input wire logic [2:0]         relay_mode,
	input wire logic signed [15:0] primary_threshold,
	input wire logic [9:0]         switching_margin,
	input wire logic [9:0]         activation_delay,
	input wire logic [9:0]         deactivation_delay,
	input wire logic [13:0]        pwm_cycle_length,
	input wire logic [13:0]        min_high_interval,
	input wire logic [13:0]        min_low_interval,
	input wire logic [1:0]         critical_reaction,
	input wire logic               relay_out,
	input wire logic               open_collector_output,
	input wire logic               indicator_led,
	input wire logic               alarm_active
);
	logic signed [17:0] up_b;
	logic signed [17:0] lo_b;
	logic [14:0]        min_sum;
	logic               on_smp;
	assign up_b    = primary_threshold + $signed({8'h0, switching_margin});
	assign lo_b    = primary_threshold - $signed({8'h0, switching_margin});
	assign min_sum = min_high_interval + min_low_interval;
	// measurement source only, so the loop gates cannot hold a change back
	assign on_smp  = sample_valid && !meas_over_range && source_select == 2'h0
		&& relay_mode == RTP_MODE_ON;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_led_tracks_out: assert property (
		indicator_led == (relay_out | open_collector_output)) else $error("led mismatch");
	a_on_above_band: assert property (
		on_smp && activation_delay == 10'h0 && meas_value > up_b |-> ##2 relay_out)
		else $error("relay not on above band");
	a_off_below_band: assert property (
		on_smp && deactivation_delay == 10'h0 && meas_value < lo_b |-> ##2 !relay_out)
		else $error("relay not off below band");
	a_alarm_from_sample: assert property (
		sample_valid && meas_over_range && relay_mode inside {[3'h1:3'h5]}
		|-> ##2 alarm_active) else $error("alarm not raised");
	a_forced_on_wins: assert property (
		(alarm_active && critical_reaction == 2'h1 && relay_mode != RTP_MODE_PWM)[*2]
		|-> relay_out) else $error("forced on ignored");
	a_forced_off_wins: assert property (
		(alarm_active && critical_reaction == 2'h2 && relay_mode < RTP_MODE_PWM)[*2]
		|-> !relay_out) else $error("forced off ignored");
	a_disabled_stays_off: assert property (
		(relay_mode == RTP_MODE_DISABLED && !alarm_active)[*3] |-> !relay_out)
		else $error("disabled relay on");
	a_bad_mins_low: assert property (
		(relay_mode == RTP_MODE_PWM && min_sum > {1'b0, pwm_cycle_length})[*2]
		|-> !$rose(open_collector_output)) else $error("pwm rose with bad minimums");
	c_forced: cover property (alarm_active && relay_out);
	c_relay_on: cover property (relay_mode == RTP_MODE_ON && relay_out);
	c_pwm_high: cover property (relay_mode == RTP_MODE_PWM && open_collector_output);
endmodule
`default_nettype wire

//--- tb/rtp_load.sv
/* rtp_load: open-collector load that meters how long the output sits high.
   assumes the bench pulses clr on a clock edge before each window. */
`timescale 1ns/1ps
`default_nettype none
module rtp_load (
	input wire logic        sys_clk,
	input wire logic        clr,
	input wire logic        open_collector_output,
	output var logic [15:0] high_cnt
);
	// a window of exactly one pwm cycle gives the high time whatever its phase
	always @(posedge sys_clk) begin
		if (clr)
			high_cnt <= 16'h0;
		else
			high_cnt <= high_cnt + {15'h0, open_collector_output};
	end
endmodule
`default_nettype wire

//--- tb/tb.sv
/* tb: self-checking bench for rtp_channel with an oc load meter.
   assumes TENTH_CYC 10: 0.1 s is 10 clocks, a 1.0 s pwm cycle 100. */
`timescale 1ns/1ps
`default_nettype none
module tb
	import rtp_pkg::*;
;
	logic               sys_clk = 1'b0, nrst = 1'b0, sample_valid = 1'b0, clr = 1'b0;
	logic               meas_over_range = 1'b0, delay_unit_minutes = 1'b0;
	logic signed [15:0] meas_value = 16'sh0, bus_value = 16'sh0, heat_value = 16'sh0;
	logic signed [15:0] cool_value = 16'sh0, loop_setpoint = 16'sh0;
	logic signed [15:0] primary_threshold = 16'sh64, secondary_threshold = 16'sh3e8;
	logic signed [15:0] pwm_span_floor = 16'sh0, pwm_span_ceiling = 16'sh64;
	logic [1:0]         source_select = 2'h0, critical_reaction = 2'h0;
	logic [2:0]         relay_mode = 3'h0;
	logic [9:0]         switching_margin = 10'ha, setpoint_deviation_gate = 10'h0;
	logic [9:0]         activation_delay = 10'h0, deactivation_delay = 10'h0;
	logic [6:0]         controller_output_gate = 7'h0, alarm_fill = 7'h0, fill_percent;
	logic [13:0]        pwm_cycle_length = 14'ha, min_high_interval = 14'h0;
	logic [13:0]        min_low_interval = 14'h0;
	logic               relay_out, open_collector_output, indicator_led, alarm_active;
	logic [15:0]        high_cnt;
	int                 bad_count = 0, num_checks = 0;

	rtp_channel #(.TENTH_CYC(10)) i_dut (.*);
	rtp_load i_load (.*);

	initial forever #50 sys_clk = ~sys_clk;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		num_checks++;
		if (got !== want) begin
			bad_count++;
			$display("[ERR] %0t got %h want %h", $time, got, want);
		end
	endtask

	// other sources carry zero, so a wrong selection shows; reads come three clocks after capture
	task automatic smp(input logic [1:0] s, input logic signed [15:0] v, input logic o);
		source_select   <= s;
		meas_value      <= s == 2'h0 ? v : 16'sh0;
		bus_value       <= s == 2'h1 ? v : 16'sh0;
		heat_value      <= s == 2'h2 ? v : 16'sh0;
		cool_value      <= s == 2'h3 ? v : 16'sh0;
		meas_over_range <= o;
		sample_valid    <= 1'b1;
		@(posedge sys_clk);
		sample_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic wait_rel(input logic e, input int n);
		repeat (n) if (relay_out !== e) @(posedge sys_clk);
		chk(relay_out, e);
		if (relay_out !== e) give_verdict();
	endtask

	task automatic t_thresh();
		relay_mode <= RTP_MODE_ON;
		for (int s = 0; s < 4; s++) begin
			smp(s[1:0], 16'sh73, 1'b0);
			chk(relay_out, 1'b1);
			chk(indicator_led, 1'b1);
			smp(s[1:0], 16'sh55, 1'b0);
			chk(relay_out, 1'b0);
		end
		relay_mode <= RTP_MODE_OFF;
		smp(2'h0, 16'sh73, 1'b0);
		chk(relay_out, 1'b0);
		smp(2'h0, 16'sh5b, 1'b0);
		chk(relay_out, 1'b0);
		smp(2'h0, 16'sh55, 1'b0);
		chk(relay_out, 1'b1);
	endtask

	task automatic t_window();
		primary_threshold   <= 16'shc8;
		secondary_threshold <= 16'shff9c;
		relay_mode          <= RTP_MODE_IN;
		smp(2'h0, 16'sh96, 1'b0);
		chk(relay_out, 1'b1);
		smp(2'h0, 16'shfa, 1'b0);
		chk(relay_out, 1'b0);
		relay_mode <= RTP_MODE_OUT;
		smp(2'h0, 16'shff6a, 1'b0);
		chk(relay_out, 1'b1);
		smp(2'h0, 16'sh96, 1'b0);
		chk(relay_out, 1'b0);
		primary_threshold <= 16'sh64;
	endtask

	task automatic t_delay();
		relay_mode <= RTP_MODE_ON;
		smp(2'h0, 16'sh55, 1'b0);
		activation_delay   <= 10'h3;
		deactivation_delay <= 10'h3;
		smp(2'h0, 16'sh73, 1'b0);
		smp(2'h0, 16'sh55, 1'b0);
		chk(relay_out, 1'b0);
		smp(2'h0, 16'sh73, 1'b0);
		chk(relay_out, 1'b0);
		wait_rel(1'b1, 40);
		smp(2'h0, 16'sh55, 1'b0);
		chk(relay_out, 1'b1);
		wait_rel(1'b0, 40);
		delay_unit_minutes <= 1'b1;
		activation_delay   <= 10'h2;
		smp(2'h0, 16'sh73, 1'b0);
		repeat (500) @(posedge sys_clk);
		chk(relay_out, 1'b0);
		wait_rel(1'b1, 800);
		delay_unit_minutes <= 1'b0;
		activation_delay   <= 10'h0;
		deactivation_delay <= 10'h0;
	endtask

	task automatic t_gate();
		setpoint_deviation_gate <= 10'h32;
		controller_output_gate  <= 7'ha;
		loop_setpoint           <= 16'sh64;
		smp(2'h0, 16'sh55, 1'b0);
		smp(2'h2, 16'sh73, 1'b0);
		chk(relay_out, 1'b0);
		loop_setpoint <= 16'sh0;
		smp(2'h2, 16'sh73, 1'b0);
		chk(relay_out, 1'b1);
		setpoint_deviation_gate <= 10'h0;
		controller_output_gate  <= 7'h0;
	endtask

	task automatic t_alarm();
		for (int r = 0; r < 3; r++) begin
			critical_reaction <= r[1:0];
			smp(2'h0, 16'sh73, 1'b0);
			smp(2'h0, 16'sh0, 1'b1);
			chk(alarm_active, 1'b1);
			chk(relay_out, r != 2);
		end
		relay_mode        <= RTP_MODE_DISABLED;
		critical_reaction <= RTP_ALM_ON;
		smp(2'h0, 16'sh0, 1'b1);
		chk(relay_out, 1'b1);
		smp(2'h0, 16'sh0, 1'b0);
		chk(relay_out, 1'b0);
		critical_reaction <= RTP_PWM_IGNORE;
	endtask

	// two cycles let the new fill latch, then one whole cycle is metered
	task automatic duty(input logic signed [15:0] v, input logic o, input logic [15:0] e);
		smp(2'h0, v, o);
		repeat (200) @(posedge sys_clk);
		clr <= 1'b1;
		@(posedge sys_clk);
		clr <= 1'b0;
		repeat (101) @(posedge sys_clk);
		chk(high_cnt, e);
	endtask

	task automatic t_pwm();
		relay_mode <= RTP_MODE_PWM;
		duty(16'shfffb, 1'b0, 16'h0);
		duty(16'sh96, 1'b0, 16'h64);
		duty(16'sh32, 1'b0, 16'h32);
		chk(fill_percent, 16'h32);
		min_high_interval <= 14'h3;
		min_low_interval  <= 14'h3;
		duty(16'sha, 1'b0, 16'h1e);
		duty(16'sh5a, 1'b0, 16'h46);
		min_high_interval <= 14'h6;
		min_low_interval  <= 14'h6;
		duty(16'sh32, 1'b0, 16'h0);
		min_high_interval <= 14'h0;
		min_low_interval  <= 14'h0;
		critical_reaction <= RTP_PWM_FORCED;
		alarm_fill        <= 7'h1e;
		duty(16'sh32, 1'b1, 16'h1e);
		chk(fill_percent, 16'h1e);
		critical_reaction <= RTP_PWM_IGNORE;
		duty(16'sh96, 1'b1, 16'h64);
		critical_reaction <= RTP_PWM_HOLD;
		duty(16'shfffb, 1'b1, 16'h64);
	endtask

	initial begin
		repeat (3) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		t_thresh();
		t_window();
		t_delay();
		t_gate();
		t_alarm();
		t_pwm();
		give_verdict();
	end
endmodule

bind rtp_channel rtp_chk i_chk (.*);
`default_nettype wire
